// ---- dv/wdr_top_test.sv ----
// Self-checking bench of the watchdog, clock monitor and reset block
`timescale 1ns/100ps
module wdr_top_test;
    import wdr_pkg::*;
    localparam int LOG2 = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic        e_clk_sense = 1'b0;
    logic        mode_a_pin = 1'b1;
    logic        mode_b_pin = 1'b1;
    logic        irq_pin_n = 1'b1;
    logic        irq_ack = 1'b0;
    logic        stop_entry = 1'b0;
    logic        irq_req, cpu_reset_n, stop_exit_delay_enable, special_mode, expansion_bus_en, periph_init;
    logic [15:0] reset_vector, compare_init;
    logic [2:0]  ccr_init;
    logic [7:0]  sci_status_init, q;
    logic        ext_rst_n = 1'b1;
    logic        e_run = 1'b1;
    logic        e;
    int          ediv = 0;
    int          n = 0;
    int          t = 0;
    int          num_errors = 0;
    int          samples_checked = 0;

    wdr_top #(.WD_BASE_LOG2(LOG2)) wdr_top_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .reset_pin_in, .reset_pin_out, .reset_pin_oe, .e_clk_sense, .mode_a_pin, .mode_b_pin,
        .irq_pin_n, .irq_ack, .stop_entry, .irq_req, .cpu_reset_n, .reset_vector, .ccr_init,
        .stop_exit_delay_enable, .special_mode, .expansion_bus_en, .periph_init, .compare_init,
        .sci_status_init
    );

    always #2.5 pclk = ~pclk;
    // Open-drain reset wire
    assign reset_pin_in = ext_rst_n & ~(reset_pin_oe & ~reset_pin_out);
    // Sensed E clock, stands still while e_run is low
    always @(posedge pclk) begin
        ediv <= (ediv == 49) ? 0 : ediv + 1;
        if (ediv == 49 && e_run) begin
            e_clk_sense <= ~e_clk_sense;
        end
    end

    // ==========================================
    // Tasks
    function automatic logic pick(input int k);
        case (k)
            0: return cpu_reset_n;
            1: return reset_pin_oe;
            default: return irq_req;
        endcase
    endfunction : pick

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        cmp({8'h0, q}, {8'h0, exp});
    endtask : chk

    task automatic wait_for(input int k, input logic v, input int lim);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        cmp({15'h0, pick(k)}, {15'h0, v});
    endtask : wait_for

    task automatic boot(input logic mb, input logic ma);
        presetn <= 1'b0;
        mode_b_pin <= mb;
        mode_a_pin <= ma;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wait_for(0, 1'b1, 100);
    endtask : boot

    // Internal reset: pin pulse length, optional external hold, release
    task automatic pin_seq(input logic hold);
        wait_for(1, 1'b1, 200);
        wait_for(1, 1'b0, 500);
        cmp({15'h0, n >= 300 && n <= 401}, 16'h0001);
        if (hold) begin
            repeat (400) @(posedge pclk);
            ext_rst_n <= 1'b1;
        end
        wait_for(0, 1'b1, 600);
    endtask : pin_seq

    // ==========================================
    // Tests
    initial begin
        #(5 * 70000);
        num_errors++;
        conclude();
    end

    initial begin
        boot(1'b1, 1'b1);
        cmp(reset_vector, 16'hfffe);
        cmp({13'h0, ccr_init}, 16'h0007);
        cmp(compare_init, 16'hffff);
        cmp({8'h0, sci_status_init}, 16'h00c0);
        cmp({12'h0, stop_exit_delay_enable, special_mode, expansion_bus_en, periph_init}, 16'h000a);
        chk(8'he4, 8'h10);
        chk(8'hfc, 8'h00);
        chk(8'hf8, 8'h10);
        chk(8'he8, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        cmp({15'h0, e}, 16'h0001);
        wr(8'he4, 8'hf9);
        chk(8'he4, 8'h39);
        wr(8'he4, 8'h06);
        chk(8'he4, 8'h31);
        wr(8'hfc, 8'hff);
        chk(8'hfc, 8'h04);
        wr(8'hfc, 8'h00);
        chk(8'hfc, 8'h04);
        irq_pin_n <= 1'b0;
        wait_for(2, 1'b1, 8);
        irq_pin_n <= 1'b1;
        repeat (4) @(posedge pclk);
        cmp({15'h0, irq_req}, 16'h0001);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        wait_for(2, 1'b0, 4);
        $display("test options done");
        wr(8'he4, 8'h08);
        chk(8'he4, 8'h39);
        e_run <= 1'b0;
        wait_for(0, 1'b0, 4300);
        cmp({15'h0, n >= 3900 && n <= 4100}, 16'h0001);
        e_run <= 1'b1;
        cmp({15'h0, periph_init}, 16'h0001);
        pin_seq(1'b0);
        cmp(reset_vector, 16'hfffc);
        chk(8'hf8, 8'h50);
        chk(8'he4, 8'h10);
        $display("test clock monitor done");
        wr(8'hfc, 8'h04);
        repeat (6500) @(posedge pclk);
        wr(8'he4, 8'h3b);
        chk(8'he4, 8'h18);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        wait_for(0, 1'b0, 10);
        ext_rst_n <= 1'b0;
        pin_seq(1'b1);
        cmp(reset_vector, 16'hfffe);
        chk(8'hf8, 8'h10);
        $display("test stop done");
        repeat (3) begin
            wr(8'he8, 8'h55);
            wr(8'he8, 8'h12);
            apb(1'b0, 8'hf8, 8'h00);
            cmp({15'h0, q[3]}, 16'h0001);
            repeat (400) @(posedge pclk);
            wr(8'he8, 8'haa);
            repeat (600) @(posedge pclk);
        end
        cmp({15'h0, cpu_reset_n}, 16'h0001);
        wr(8'he8, 8'haa);
        wait_for(0, 1'b0, 1200);
        cmp({15'h0, n >= 700 && n <= 1100}, 16'h0001);
        pin_seq(1'b0);
        cmp(reset_vector, 16'hfffa);
        chk(8'hf8, 8'h90);
        for (int r = 1; r < 3; r++) begin
            wr(8'he4, r[7:0]);
            wr(8'he8, 8'h55);
            wr(8'he8, 8'haa);
            wait_for(0, 1'b0, 26000);
            t = (1 << (LOG2 + 2 * r)) * 100;
            cmp({15'h0, n >= t - 100 && n <= t + 2}, 16'h1);
            pin_seq(1'b0);
        end
        $display("test watchdog done");
        boot(1'b0, 1'b0);
        cmp(reset_vector, 16'hbffe);
        chk(8'hfc, 8'h04);
        chk(8'hf8, 8'h21);
        wr(8'he4, 8'h13);
        wr(8'he4, 8'h03);
        chk(8'he4, 8'h03);
        cmp({15'h0, stop_exit_delay_enable}, 16'h0000);
        irq_pin_n <= 1'b0;
        wait_for(2, 1'b1, 8);
        irq_pin_n <= 1'b1;
        wait_for(2, 1'b0, 8);
        wr(8'hfc, 8'h00);
        chk(8'hfc, 8'h00);
        $display("test special mode done");
        conclude();
    end
endmodule : wdr_top_test

// ---- rtl/wdr_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the reset block
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH
`define WDR_IDX_OPTIONS     6'h39
`define WDR_IDX_SERVICE     6'h3a
`define WDR_IDX_STATUS      6'h3e
`define WDR_IDX_CONFIG      6'h3f
`define WDR_SVC_ARM         8'h55
`define WDR_SVC_CLEAR       8'haa
`define WDR_OPT_IRQ_EDGE_SELECT        5
`define WDR_OPT_DLY         4
`define WDR_OPT_CME         3
`define WDR_CFG_WATCHDOG_DISABLE       2
`define WDR_VEC_NORM_HI     8'hff
`define WDR_VEC_SPEC_HI     8'hbf
`define WDR_VEC_EXT_LO      8'hfe
`define WDR_VEC_CMON_LO     8'hfc
`define WDR_VEC_WDOG_LO     8'hfa
`define WDR_MAP_INIT        8'h00
`define WDR_TIMER_CNT_INIT  16'h0000
`define WDR_COMPARE_INIT    16'hffff
`define WDR_SCI_STATUS_INIT 8'hc0
`define WDR_CCR_INIT        3'b111
`define WDR_PCLK_NS         5
`define WDR_E_DIV           100
`define WDR_CM_DELAY_NS     20000
`define WDR_CM_CYC          ((`WDR_CM_DELAY_NS + `WDR_PCLK_NS - 1) / `WDR_PCLK_NS)
`define WDR_WIN_E           7'd64
`define WDR_DRIVE_E         3'd4
`define WDR_SAMPLE_E        3'd2
`define WDR_WD_BASE_LOG2    15
`endif

// ---- rtl/wdr_clk_mon.sv ----
// Clock-loss detector watching the sensed E clock
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module wdr_clk_mon (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,
    input  wire logic clk_sense,
    output      logic fail
);
    import wdr_pkg::*;
    localparam logic [11:0] LIMIT = 12'(`WDR_CM_CYC - 1);
    wdr_cmon_t s;
    wdr_cmon_t n;

    always_comb begin
        n      = s;
        n.s1   = clk_sense;
        n.s2   = s.s1;
        n.s3   = s.s2;
        n.fail = 1'b0;
        // Any edge restarts the delay; a gap as long as it is a loss
        if (!enable || (s.s2 != s.s3)) begin
            n.cnt = '0;
        end else if (s.cnt == LIMIT) begin
            n.fail = 1'b1;
        end else begin
            n.cnt = s.cnt + 12'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign fail = s.fail;
endmodule : wdr_clk_mon

// ---- rtl/wdr_pkg.sv ----
// Types of the watchdog, clock monitor and reset block
package wdr_pkg;
    typedef enum logic [1:0] {ST_HOLD, ST_DRIVE, ST_WAIT, ST_RUN} wdr_phase_t;
    typedef enum logic [1:0] {CAUSE_EXT, CAUSE_CMON, CAUSE_WDOG} wdr_cause_t;
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic [11:0] cnt;
        logic        fail;
    } wdr_cmon_t;
    typedef struct packed {
        wdr_phase_t  phase;
        wdr_cause_t  cause;
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic        irq_prev;
        logic [7:0]  ediv;
        logic        etick;
        logic [2:0]  ecnt;
        logic [6:0]  win;
        logic        opt_lock;
        logic        cfg_lock;
        logic        irq_edge_select;
        logic        dly;
        logic        clock_monitor_enable;
        logic [1:0]  rate;
        logic        watchdog_disable;
        logic        special;
        logic        expanded;
        logic        armed;
        logic [20:0] wd_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        rst_oe;
        logic        cpu_rst_n;
        logic [15:0] vector;
        logic        irq_req;
        logic [2:0]  ccr_init;
        logic [15:0] compare_init;
        logic [7:0]  sci_status_init;
    } wdr_state_t;
endpackage : wdr_pkg

// ---- rtl/wdr_top.sv ----
// Watchdog, clock monitor, configuration bits and reset sequencer
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "wdr_cfg.svh"
module wdr_top #(
    parameter int WD_BASE_LOG2 = `WDR_WD_BASE_LOG2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        reset_pin_in,
    output      logic        reset_pin_out,
    output      logic        reset_pin_oe,
    input  wire logic        e_clk_sense,
    input  wire logic        mode_a_pin,
    input  wire logic        mode_b_pin,
    input  wire logic        irq_pin_n,
    input  wire logic        irq_ack,
    input  wire logic        stop_entry,
    output      logic        irq_req,
    output      logic        cpu_reset_n,
    output      logic [15:0] reset_vector,
    output      logic [2:0]  ccr_init,
    output      logic        stop_exit_delay_enable,
    output      logic        special_mode,
    output      logic        expansion_bus_en,
    output      logic        periph_init,
    output      logic [15:0] compare_init,
    output      logic [7:0]  sci_status_init
);
    import wdr_pkg::*;

    // Irq pin stages start at the pin's idle high level: no request out of reset
    localparam wdr_state_t RST = '{phase: ST_HOLD, cause: CAUSE_EXT, s1: 4'h1, s2: 4'h1,
        irq_prev: 1'b1, ediv: 8'h00, etick: 1'b0, ecnt: 3'h0, win: 7'h00, opt_lock: 1'b0,
        cfg_lock: 1'b0, irq_edge_select: 1'b0, dly: 1'b1, clock_monitor_enable: 1'b0, rate: 2'h0, watchdog_disable: 1'b0,
        special: 1'b0, expanded: 1'b0, armed: 1'b0, wd_cnt: 21'h0, prdata: 32'h0,
        pready: 1'b0, pslverr: 1'b0, rst_oe: 1'b0, cpu_rst_n: 1'b0, vector: 16'h0,
        irq_req: 1'b0, ccr_init: `WDR_CCR_INIT, compare_init: `WDR_COMPARE_INIT,
        sci_status_init: `WDR_SCI_STATUS_INIT};
    localparam logic [7:0] A_OPT = {`WDR_IDX_OPTIONS, 2'b00};
    localparam logic [7:0] A_SVC = {`WDR_IDX_SERVICE, 2'b00};
    localparam logic [7:0] A_STA = {`WDR_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_CFG = {`WDR_IDX_CONFIG, 2'b00};

    wdr_state_t  s;
    wdr_state_t  n;
    logic        cm_fail;
    logic        pin_hi;
    logic        release_now;
    logic        setup;
    logic        wr;
    logic        prot_opt;
    logic        prot_cfg;
    logic        wd_hit;
    logic [20:0] wd_limit;
    logic [7:0]  opt_byte;
    logic [7:0]  cfg_byte;

    // =========================================================
    // Clock monitor
    wdr_clk_mon u_cmon (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (s.clock_monitor_enable && (s.phase == ST_RUN)),
        .clk_sense (e_clk_sense),
        .fail      (cm_fail)
    );

    // =========================================================
    // Next-state logic
    always_comb begin
        n           = s;
        release_now = 1'b0;
        n.pready    = 1'b0;
        n.pslverr   = 1'b0;
        n.s1        = {reset_pin_in, mode_a_pin, mode_b_pin, irq_pin_n};
        n.s2        = s.s1;
        n.irq_prev  = s.s2[0];
        pin_hi      = s.s2[3];
        setup       = psel && !penable;
        wr          = psel && penable && s.pready && pwrite && !s.pslverr;
        prot_opt    = s.special || (!s.opt_lock && (s.win < `WDR_WIN_E));
        prot_cfg    = s.special || (!s.cfg_lock && (s.win < `WDR_WIN_E));
        opt_byte    = {2'b00, s.irq_edge_select, s.dly, s.clock_monitor_enable, 1'b0, s.rate};
        cfg_byte    = {5'b00000, s.watchdog_disable, 2'b00};
        wd_limit    = 21'((64'd1 << (WD_BASE_LOG2 + 2 * int'(s.rate))) - 64'd1);
        wd_hit      = s.etick && (s.wd_cnt >= wd_limit);

        // E clock enable
        n.etick = 1'b0;
        if (s.ediv == 8'(`WDR_E_DIV - 1)) begin
            n.ediv  = 8'h00;
            n.etick = 1'b1;
        end else begin
            n.ediv = s.ediv + 8'h01;
        end

        // Irq pin sense
        if (s.irq_edge_select) begin
            if (s.irq_prev && !s.s2[0]) begin
                n.irq_req = 1'b1;
            end else if (irq_ack) begin
                n.irq_req = 1'b0;
            end
        end else begin
            n.irq_req = !s.s2[0];
        end

        // Register reads
        if (setup) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            unique case (paddr)
                A_OPT: n.prdata = {24'h0, opt_byte};
                A_SVC: n.prdata = 32'h0;
                A_CFG: n.prdata = {24'h0, cfg_byte};
                A_STA: n.prdata = {24'h0, s.cause, s.special, s.expanded, s.armed,
                                   s.opt_lock, s.cfg_lock, s.watchdog_disable};
                default: n.pslverr = 1'b1;
            endcase
        end

        unique case (s.phase)
            ST_HOLD: begin
                if (pin_hi) begin
                    release_now = 1'b1;
                end
            end
            ST_DRIVE: begin
                if (s.etick) begin
                    if (s.ecnt == `WDR_DRIVE_E - 3'd1) begin
                        n.ecnt   = 3'd0;
                        n.rst_oe = 1'b0;
                        n.phase  = ST_WAIT;
                    end else begin
                        n.ecnt = s.ecnt + 3'd1;
                    end
                end
            end
            ST_WAIT: begin
                if (s.etick) begin
                    if (s.ecnt == `WDR_SAMPLE_E - 3'd1) begin
                        n.ecnt = 3'd0;
                        if (pin_hi) begin
                            release_now = 1'b1;
                        end else begin
                            n.cause = CAUSE_EXT;
                            n.phase = ST_HOLD;
                        end
                    end else begin
                        n.ecnt = s.ecnt + 3'd1;
                    end
                end
            end
            ST_RUN: begin
                if (s.etick && (s.win < `WDR_WIN_E)) begin
                    n.win = s.win + 7'd1;
                end
                if (s.etick) begin
                    n.wd_cnt = s.wd_cnt + 21'd1;
                end
                if (wr) begin
                    unique case (paddr)
                        A_OPT: begin
                            n.clock_monitor_enable = pwdata[`WDR_OPT_CME];
                            if (prot_opt) begin
                                n.irq_edge_select     = pwdata[`WDR_OPT_IRQ_EDGE_SELECT];
                                n.dly      = pwdata[`WDR_OPT_DLY];
                                n.rate     = pwdata[1:0];
                                n.opt_lock = 1'b1;
                            end
                        end
                        A_CFG: begin
                            if (prot_cfg) begin
                                n.watchdog_disable    = pwdata[`WDR_CFG_WATCHDOG_DISABLE];
                                n.cfg_lock = 1'b1;
                            end
                        end
                        A_SVC: begin
                            if (pwdata[7:0] == `WDR_SVC_ARM) begin
                                n.armed = 1'b1;
                            end else if ((pwdata[7:0] == `WDR_SVC_CLEAR) && s.armed) begin
                                n.armed  = 1'b0;
                                n.wd_cnt = 21'h0;
                            end
                        end
                        default: ;
                    endcase
                end
                if (!pin_hi) begin
                    n.cause = CAUSE_EXT;
                    n.phase = ST_HOLD;
                end else if (s.clock_monitor_enable && (cm_fail || stop_entry)) begin
                    n.cause  = CAUSE_CMON;
                    n.phase  = ST_DRIVE;
                    n.rst_oe = 1'b1;
                    n.ecnt   = 3'd0;
                end else if (wd_hit && !s.watchdog_disable) begin
                    n.cause  = CAUSE_WDOG;
                    n.phase  = ST_DRIVE;
                    n.rst_oe = 1'b1;
                    n.ecnt   = 3'd0;
                end
            end
        endcase

        // Option bits, arm, watchdog count, window, locks and CPU reset held at initial state outside run
        if (s.phase != ST_RUN) begin
            n.clock_monitor_enable       = 1'b0;
            n.irq_edge_select      = 1'b0;
            n.dly       = 1'b1;
            n.rate      = 2'b00;
            n.armed     = 1'b0;
            n.wd_cnt    = 21'h0;
            n.win       = 7'h00;
            n.opt_lock  = 1'b0;
            n.cfg_lock  = 1'b0;
            n.cpu_rst_n = 1'b0;
        end
        if (release_now) begin
            n.phase     = ST_RUN;
            n.cpu_rst_n = 1'b1;
            n.special   = !s.s2[1];
            n.expanded  = s.s2[2];
            n.watchdog_disable     = !s.s2[1];
            n.vector[15:8] = s.s2[1] ? `WDR_VEC_NORM_HI : `WDR_VEC_SPEC_HI;
            unique case (n.cause)
                CAUSE_CMON: n.vector[7:0] = `WDR_VEC_CMON_LO;
                CAUSE_WDOG: n.vector[7:0] = `WDR_VEC_WDOG_LO;
                default:    n.vector[7:0] = `WDR_VEC_EXT_LO;
            endcase
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    // =========================================================
    // Outputs
    assign prdata                 = s.prdata;
    assign pready                 = s.pready;
    assign pslverr                = s.pslverr;
    assign reset_pin_out          = 1'b0;
    assign reset_pin_oe           = s.rst_oe;
    assign irq_req                = s.irq_req;
    assign cpu_reset_n            = s.cpu_rst_n;
    assign reset_vector           = s.vector;
    assign ccr_init               = s.ccr_init;
    assign stop_exit_delay_enable = s.dly;
    assign special_mode           = s.special;
    assign expansion_bus_en       = s.expanded;
    // Peripherals hold init values: map 0, timer 0, wired-OR and enables off
    assign periph_init            = !s.cpu_rst_n;
    assign compare_init           = s.compare_init;
    assign sci_status_init        = s.sci_status_init;

    // =========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SVC_CLEAR: assert property (wr && paddr == A_SVC && pwdata[7:0] == 8'haa && s.armed
        && s.phase == ST_RUN && pin_hi && !s.etick |=> s.wd_cnt == 21'h0 && !s.armed)
        else $error("service pair did not clear watchdog");
    AST_SVC_OTHER: assert property (wr && paddr == A_SVC && pwdata[7:0] != 8'h55
        && pwdata[7:0] != 8'haa && s.phase == ST_RUN && pin_hi |=> $stable(s.armed))
        else $error("stray service value changed arm state");
    AST_CM_RESET: assert property (s.phase == ST_RUN && pin_hi && s.clock_monitor_enable && cm_fail
        |=> s.phase == ST_DRIVE && s.cause == CAUSE_CMON && reset_pin_oe)
        else $error("clock loss did not start reset");
    AST_STOP_CM: assert property (s.phase == ST_RUN && pin_hi && s.clock_monitor_enable && stop_entry
        |=> s.cause == CAUSE_CMON && s.phase == ST_DRIVE)
        else $error("stop with monitor on did not reset");
    AST_LOCK: assert property (wr && paddr == A_OPT && !s.special && s.opt_lock
        && s.phase == ST_RUN && pin_hi |=> $stable(s.rate) && $stable(s.irq_edge_select))
        else $error("protected bits written twice");
    AST_WD_FIRE: assert property (s.phase == ST_RUN && pin_hi && !s.clock_monitor_enable && wd_hit
        && !s.watchdog_disable |=> s.phase == ST_DRIVE && s.cause == CAUSE_WDOG)
        else $error("watchdog time-out missed");
    AST_WATCHDOG_DISABLE: assert property (s.phase == ST_RUN && pin_hi && !s.clock_monitor_enable && s.watchdog_disable
        |=> s.phase == ST_RUN)
        else $error("disabled watchdog reset the part");
    AST_DRIVE_PIN: assert property ($fell(reset_pin_oe) |-> s.phase == ST_WAIT
        && $past(s.ecnt) == 3'd3)
        else $error("reset pin drive length wrong");
    AST_VECTOR: assert property ($rose(cpu_reset_n) |-> reset_vector[7:0] ==
        (s.cause == CAUSE_CMON ? 8'hfc : s.cause == CAUSE_WDOG ? 8'hfa : 8'hfe)
        && reset_vector[15:8] == (s.special ? 8'hbf : 8'hff))
        else $error("reset vector does not match cause");
    AST_RESV: assert property (pready && !pslverr && $past(paddr) == A_OPT
        |-> prdata[7:6] == 2'b00 && prdata[2] == 1'b0)
        else $error("unimplemented option bits read nonzero");
    AST_INIT: assert property (!cpu_reset_n |-> !s.clock_monitor_enable && s.dly && s.rate == 2'b00)
        else $error("control bits not at reset state");
    AST_IRQ_LVL: assert property (!s.irq_edge_select ##1 !s.irq_edge_select |-> irq_req == !$past(s.s2[0]))
        else $error("level irq sense wrong");

    COV_WDOG: cover property ($rose(cpu_reset_n) && s.cause == CAUSE_WDOG);
    COV_CMON: cover property ($rose(cpu_reset_n) && s.cause == CAUSE_CMON);
    COV_SERVICE: cover property (s.armed ##[1:20] !s.armed && s.wd_cnt == 21'h0);
endmodule : wdr_top
